// ### logic/pmoc_regs.sv
// Output configuration command group: scaling, floor limit, switching rate, start threshold
`timescale 1ns/1ns
`include "pmoc_defs.svh"

module pmoc_regs #(
  parameter logic [10:0] NVM_SCALE_MAN = 11'h040,
  parameter logic [15:0] NVM_FLOOR     = 16'h0000,
  parameter int          NVM_FREQ_KHZ  = 550,
  parameter logic [10:0] NVM_VIN_MAN   = 11'h014,
  parameter logic [15:0] LIMIT_LO      = 16'h0000,
  parameter logic [15:0] LIMIT_HI      = 16'hFFFF
) (
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire pmoc_pkg::pmoc_cmd_t cmd,
  input  wire logic               store_user_all,
  input  wire logic               restore_user_all,
  input  wire logic               conv_en,
  input  wire logic               analog_supply_uvlo,
  input  wire logic               input_above_start,
  input  wire logic [15:0]        vout_target,
  input  wire logic               vout_target_chg,
  input  wire logic               status_clear,
  output logic [15:0]             rd_data_q,
  output logic                    rd_valid_q,
  output pmoc_pkg::pmoc_status_t  status_q,
  output logic                    output_limit_warning_q,
  output logic [15:0]             vout_setpoint_q,
  output logic [1:0]              div_factor_q,
  output logic                    scale_use_programmed_q,
  output logic [15:0]             scale_hw_word_q,
  output logic [10:0]             eff_freq_khz_q,
  output logic [5:0]              input_start_threshold_quarter_v_q,
  output logic                    input_low_fault_mask_q
);
  import pmoc_pkg::*;

  // ----------------------------------------------------------------------
  // Linear word to fixed point, 16 fraction bits
  // ----------------------------------------------------------------------
  function automatic logic signed [47:0] lin_fx(input logic [15:0] w);
    logic signed [47:0] m;
    logic [5:0]         s;
    m = 48'(signed'(w[`PMOC_MAN_HI:`PMOC_MAN_LO]));
    s = {w[`PMOC_EXP_HI], w[`PMOC_EXP_HI:`PMOC_EXP_LO]} + 6'd16;
    lin_fx = m <<< s[4:0];
  endfunction : lin_fx

  // Exponent chosen so the mantissa stays within its signed range
  localparam logic [4:0]  FREQ_EXP_RST = (NVM_FREQ_KHZ > `PMOC_MAN_MAX) ?
                                         `PMOC_FREQ_EXP_BIG : `PMOC_FREQ_EXP_SMALL;
  localparam logic [10:0] FREQ_MAN_RST = (NVM_FREQ_KHZ > `PMOC_MAN_MAX) ?
                                         11'(NVM_FREQ_KHZ / 2) : 11'(NVM_FREQ_KHZ);

  // ----------------------------------------------------------------------
  // Registers and NVM image
  // ----------------------------------------------------------------------
  logic [15:0]        scale_q, floor_q, freq_q, vin_q;
  logic [15:0]        nvm_scale_q, nvm_floor_q, nvm_freq_q, nvm_vin_q;
  logic [15:0]        freq_hw_q;
  logic               uvlo_meta_q, uvlo_q, uvlo_prev_q, above_meta_q, above_q;

  logic               wr_scale, wr_floor, wr_freq, wr_vin;
  logic               scale_ok, floor_ok, freq_ok, vin_ok;
  logic               hw_reload, limit_event, bad_write;
  logic signed [47:0] wr_fx, scale_fx, vin_fx;
  logic signed [31:0] freq_khz;
  logic signed [33:0] vin_qv;
  logic [10:0]        eff_freq_d;

  // ----------------------------------------------------------------------
  // Write decode and range checks
  // ----------------------------------------------------------------------
  assign wr_fx    = lin_fx(cmd.data);
  assign wr_scale = cmd.wr && (cmd.code == `PMOC_CMD_SCALE);
  assign wr_floor = cmd.wr && (cmd.code == `PMOC_CMD_FLOOR);
  assign wr_freq  = cmd.wr && (cmd.code == `PMOC_CMD_FREQ);
  assign wr_vin   = cmd.wr && (cmd.code == `PMOC_CMD_INPUT_START_THRESHOLD);

  assign scale_ok = (wr_fx > 48'sd0) && (wr_fx <= `PMOC_FX_ONE);
  assign floor_ok = (cmd.data >= LIMIT_LO) && (cmd.data <= LIMIT_HI);
  assign freq_ok  = (wr_fx > 48'sd0) && (wr_fx[47:16] < `PMOC_FREQ_TOP_KHZ);
  assign vin_ok   = (wr_fx[47:14] >= `PMOC_VIN_Q_MIN) && (wr_fx[47:14] <= `PMOC_VIN_Q_MAX);

  assign bad_write = (wr_scale && !scale_ok) || (wr_floor && !floor_ok)
                   || (wr_freq && !freq_ok) || (wr_vin && !vin_ok);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      uvlo_meta_q  <= 1'b0;
      uvlo_q       <= 1'b0;
      uvlo_prev_q  <= 1'b0;
      above_meta_q <= 1'b0;
      above_q      <= 1'b0;
    end
    else
    begin
      uvlo_meta_q  <= analog_supply_uvlo;
      uvlo_q       <= uvlo_meta_q;
      uvlo_prev_q  <= uvlo_q;
      above_meta_q <= input_above_start;
      above_q      <= above_meta_q;
    end
  end

  // Supply leaving lockout, or a restore, pushes held values to hardware
  assign hw_reload = (uvlo_prev_q && !uvlo_q) || restore_user_all;

  // ----------------------------------------------------------------------
  // Command registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      scale_q <= {`PMOC_SCALE_EXP_RST, NVM_SCALE_MAN};
      floor_q <= NVM_FLOOR;
      freq_q  <= {FREQ_EXP_RST, FREQ_MAN_RST};
      vin_q   <= {`PMOC_VIN_EXP_RST, NVM_VIN_MAN};
    end
    else if (restore_user_all)
    begin
      scale_q <= nvm_scale_q;
      floor_q <= nvm_floor_q;
      freq_q  <= nvm_freq_q;
      vin_q   <= nvm_vin_q;
    end
    else
    begin
      // Stored exactly as written, whatever hardware can really do
      scale_q <= (wr_scale && scale_ok) ? cmd.data : scale_q;
      floor_q <= (wr_floor && floor_ok) ? cmd.data : floor_q;
      freq_q  <= (wr_freq && freq_ok) ? cmd.data : freq_q;
      vin_q   <= (wr_vin && vin_ok) ? cmd.data : vin_q;
    end
  end

  // ----------------------------------------------------------------------
  // NVM image
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      nvm_scale_q <= {`PMOC_SCALE_EXP_RST, NVM_SCALE_MAN};
      nvm_floor_q <= NVM_FLOOR;
      nvm_freq_q  <= {FREQ_EXP_RST, FREQ_MAN_RST};
      nvm_vin_q   <= {`PMOC_VIN_EXP_RST, NVM_VIN_MAN};
    end
    else if (store_user_all)
    begin
      nvm_scale_q <= scale_q;
      nvm_floor_q <= floor_q;
      nvm_freq_q  <= freq_q;
      nvm_vin_q   <= vin_q;
    end
  end

  // ----------------------------------------------------------------------
  // Hardware copies of scale and frequency
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      scale_hw_word_q <= {`PMOC_SCALE_EXP_RST, NVM_SCALE_MAN};
      freq_hw_q       <= {FREQ_EXP_RST, FREQ_MAN_RST};
    end
    else if (hw_reload)
    begin
      // A restore takes the image, a lockout exit the held registers
      scale_hw_word_q <= restore_user_all ? nvm_scale_q : scale_q;
      freq_hw_q       <= restore_user_all ? nvm_freq_q : freq_q;
    end
    else if (!conv_en)
    begin
      // Enabled writes are only stored, switching must not glitch mid-run
      scale_hw_word_q <= (wr_scale && scale_ok) ? cmd.data : scale_hw_word_q;
      freq_hw_q       <= (wr_freq && freq_ok) ? cmd.data : freq_hw_q;
    end
  end

  // ----------------------------------------------------------------------
  // Divider factor selection
  // ----------------------------------------------------------------------
  assign scale_fx = lin_fx(scale_hw_word_q);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      div_factor_q           <= `PMOC_DIV_ONE;
      scale_use_programmed_q <= 1'b0;
    end
    else
    begin
      div_factor_q <= (scale_fx <= `PMOC_FX_EIGHTH)  ? `PMOC_DIV_EIGHTH  :
                      (scale_fx <= `PMOC_FX_QUARTER) ? `PMOC_DIV_QUARTER :
                      (scale_fx <= `PMOC_FX_HALF)    ? `PMOC_DIV_HALF    : `PMOC_DIV_ONE;
      // Reference math then follows scale_hw_word_q, not the divider code
      scale_use_programmed_q <= (scale_fx != `PMOC_FX_EIGHTH) && (scale_fx != `PMOC_FX_QUARTER)
                             && (scale_fx != `PMOC_FX_HALF) && (scale_fx != `PMOC_FX_ONE);
    end
  end

  // ----------------------------------------------------------------------
  // Effective switching frequency
  // ----------------------------------------------------------------------
  assign freq_khz = 32'(lin_fx(freq_hw_q) >>> 16);

  // Band edges are open upward so a gap value lands in the next band
  localparam int          BAND_TOP [11] = '{250, 300, 350, 410, 500, 600, 700, 820, 1000, 1200, 1400};
  localparam logic [10:0] BAND_KHZ [12] = '{11'd225, 11'd275, 11'd325, 11'd375, 11'd450, 11'd550, 11'd650,
                                            11'd750, 11'd900, 11'd1100, 11'd1300, 11'd1500};

  always_comb
  begin
    eff_freq_d = BAND_KHZ[11];
    for (int i = 10; i >= 0; i--)
    begin
      if (freq_khz < BAND_TOP[i])
      begin
        eff_freq_d = BAND_KHZ[i];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      eff_freq_khz_q <= 11'd0;
    end
    else
    begin
      eff_freq_khz_q <= eff_freq_d;
    end
  end

  // ----------------------------------------------------------------------
  // Start threshold and low-input fault mask
  // ----------------------------------------------------------------------
  assign vin_fx = lin_fx(vin_q);
  assign vin_qv = vin_fx[47:14];

  // Truncation of the fraction rounds down to the next quarter volt
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      input_start_threshold_quarter_v_q <= 6'(`PMOC_VIN_Q_MIN);
    end
    else
    begin
      input_start_threshold_quarter_v_q <= (vin_qv < `PMOC_VIN_Q_MIN) ? 6'(`PMOC_VIN_Q_MIN) :
                            (vin_qv > `PMOC_VIN_Q_MAX) ? 6'(`PMOC_VIN_Q_MAX) : vin_qv[5:0];
    end
  end

  // Only a reset re-arms; enable toggles and NVM moves leave it alone
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      input_low_fault_mask_q <= 1'b1;
    end
    else if (above_q)
    begin
      input_low_fault_mask_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Floor clamp and warning
  // ----------------------------------------------------------------------
  assign limit_event = conv_en && ((vout_target_chg && (vout_target < floor_q))
                     || (wr_floor && floor_ok && (vout_target < cmd.data)));

  // Slewing toward the clamp is left to the analog loop
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      vout_setpoint_q        <= NVM_FLOOR;
      output_limit_warning_q <= 1'b0;
    end
    else
    begin
      vout_setpoint_q        <= (vout_target < floor_q) ? floor_q : vout_target;
      output_limit_warning_q <= limit_event;
    end
  end

  // ----------------------------------------------------------------------
  // Status bits, set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      status_q <= '0;
    end
    else
    begin
      status_q.nota   <= limit_event || (status_q.nota && !status_clear);
      status_q.vout   <= limit_event || (status_q.vout && !status_clear);
      status_q.minmax <= limit_event || (status_q.minmax && !status_clear);
      status_q.cml    <= bad_write || (status_q.cml && !status_clear);
      status_q.alert  <= limit_event || bad_write || (status_q.alert && !status_clear);
    end
  end

  // ----------------------------------------------------------------------
  // Word read
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= cmd.rd;
      if (cmd.rd)
      begin
        case (cmd.code)
          `PMOC_CMD_SCALE:  rd_data_q <= scale_q;
          `PMOC_CMD_FLOOR:  rd_data_q <= floor_q;
          `PMOC_CMD_FREQ:   rd_data_q <= freq_q;
          `PMOC_CMD_INPUT_START_THRESHOLD: rd_data_q <= vin_q;
          default:          rd_data_q <= 16'h0000;
        endcase
      end
    end
  end

endmodule : pmoc_regs

// ### shared/pmoc_defs.svh
// Offsets, field positions, reset values and limits of the output configuration commands
`ifndef PMOC_DEFS_SVH
`define PMOC_DEFS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define PMOC_CMD_SCALE      8'h29
`define PMOC_CMD_FLOOR      8'h2B
`define PMOC_CMD_FREQ       8'h33
`define PMOC_CMD_INPUT_START_THRESHOLD     8'h35

// ----------------------------------------------------------------------
// Linear word fields
// ----------------------------------------------------------------------
`define PMOC_EXP_HI         15
`define PMOC_EXP_LO         11
`define PMOC_MAN_HI         10
`define PMOC_MAN_LO         0
`define PMOC_SCALE_EXP_RST  5'h19
`define PMOC_VIN_EXP_RST    5'h1E
`define PMOC_FREQ_EXP_BIG   5'h01
`define PMOC_FREQ_EXP_SMALL 5'h00
`define PMOC_MAN_MAX        1023

// ----------------------------------------------------------------------
// Decoded limits: FX values with 16 fraction bits, frequency top in kHz, input limits in quarter volts
// ----------------------------------------------------------------------
`define PMOC_FX_EIGHTH      48'sh0000_0000_2000
`define PMOC_FX_QUARTER     48'sh0000_0000_4000
`define PMOC_FX_HALF        48'sh0000_0000_8000
`define PMOC_FX_ONE         48'sh0000_0001_0000
`define PMOC_FREQ_TOP_KHZ   32'sd1650
`define PMOC_VIN_Q_MIN      34'sd10
`define PMOC_VIN_Q_MAX      34'sd63

// ----------------------------------------------------------------------
// Divider factor codes
// ----------------------------------------------------------------------
`define PMOC_DIV_EIGHTH     2'h0
`define PMOC_DIV_QUARTER    2'h1
`define PMOC_DIV_HALF       2'h2
`define PMOC_DIV_ONE        2'h3

`endif

// ### shared/pmoc_pkg.sv
// Types shared by the output configuration command block
package pmoc_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] data;
  } pmoc_cmd_t;

  typedef struct packed {
    logic nota;
    logic vout;
    logic minmax;
    logic cml;
    logic alert;
  } pmoc_status_t;

endpackage : pmoc_pkg

// ### test/pmoc_host.sv
// Host side model issuing word reads and writes on the command port
`timescale 1ns/1ns
module pmoc_host (
  input  logic                mclk,
  output pmoc_pkg::pmoc_cmd_t cmd,
  input  logic [15:0]         rd_data_q,
  input  logic                rd_valid_q
);
  import pmoc_pkg::*;
  initial cmd = '0;
  // Released fields show inverted data, never the last value
  task automatic wr_word(input logic [7:0] code, input logic [15:0] data);
    @(negedge mclk);
    cmd <= '{1'b1, 1'b0, code, data};
    @(negedge mclk);
    cmd <= '{1'b0, 1'b0, ~code, ~data};
  endtask : wr_word
  task automatic rd_word(input logic [7:0] code, output logic [15:0] data);
    int n;
    @(negedge mclk);
    cmd <= '{1'b0, 1'b1, code, 16'h5A5A};
    @(negedge mclk);
    cmd <= '{1'b0, 1'b0, ~code, 16'hA5A5};
    n = 0;
    while (rd_valid_q !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    data = (rd_valid_q === 1'b1) ? rd_data_q : 16'hDEAD;
  endtask : rd_word
endmodule : pmoc_host

// ### test/pmoc_regs_checker.sv
// Port level assertions for the output configuration commands
`timescale 1ns/1ns
module pmoc_chk (
  input logic                   mclk,
  input logic                   sys_rst,
  input pmoc_pkg::pmoc_cmd_t    cmd,
  input logic                   restore_user_all,
  input logic                   conv_en,
  input logic                   analog_supply_uvlo,
  input logic [15:0]            vout_target,
  input logic                   vout_target_chg,
  input logic                   rd_valid_q,
  input pmoc_pkg::pmoc_status_t status_q,
  input logic                   output_limit_warning_q,
  input logic [15:0]            vout_setpoint_q,
  input logic [15:0]            scale_hw_word_q,
  input logic [10:0]            eff_freq_khz_q,
  input logic [5:0]             input_start_threshold_quarter_v_q,
  input logic                   input_low_fault_mask_q
);
  import pmoc_pkg::*;
  // Lockout input low long enough that no reload is still in flight
  logic [2:0] uv_low_q;
  always_ff @(posedge mclk) uv_low_q <= (sys_rst || analog_supply_uvlo) ? 3'h0 : uv_low_q + {2'h0, uv_low_q != 3'h7};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_read_answer:
    assert property (cmd.rd |=> rd_valid_q) else $error("read not answered");
  chk_read_single:
    assert property (!cmd.rd |=> !rd_valid_q) else $error("stray read valid");
  chk_warn_status:
    assert property (output_limit_warning_q |-> status_q.nota && status_q.vout && status_q.minmax && status_q.alert)
      else $error("warning status missing");
  chk_warn_cause:
    assert property (output_limit_warning_q |-> $past(conv_en) && ($past(vout_target_chg) || $past(cmd.wr)))
      else $error("warning without cause");
  chk_floor_clamp:
    assert property (1'b1 |=> vout_setpoint_q >= $past(vout_target)) else $error("setpoint below target");
  chk_invalid_alert:
    assert property (status_q.cml |-> status_q.alert) else $error("invalid data without alert");
  chk_hold_enabled:
    assert property (conv_en && !restore_user_all && uv_low_q == 3'h7 |=> $stable(scale_hw_word_q))
      else $error("hardware scale changed while enabled");
  chk_mask_sticky:
    assert property (!input_low_fault_mask_q |=> !input_low_fault_mask_q) else $error("fault mask re-armed");
  chk_vin_range:
    assert property (input_start_threshold_quarter_v_q >= 6'h0A) else $error("start threshold below range");
  chk_freq_table:
    assert property (!$past(sys_rst) |-> eff_freq_khz_q inside {11'h0E1, 11'h113, 11'h145, 11'h177, 11'h1C2,
      11'h226, 11'h28A, 11'h2EE, 11'h384, 11'h44C, 11'h514, 11'h5DC}) else $error("frequency off table");
endmodule : pmoc_chk
bind pmoc_regs pmoc_chk chk (.mclk(mclk), .sys_rst(sys_rst), .cmd(cmd), .restore_user_all(restore_user_all),
  .conv_en(conv_en), .analog_supply_uvlo(analog_supply_uvlo), .vout_target(vout_target),
  .vout_target_chg(vout_target_chg), .rd_valid_q(rd_valid_q), .status_q(status_q),
  .output_limit_warning_q(output_limit_warning_q), .vout_setpoint_q(vout_setpoint_q),
  .scale_hw_word_q(scale_hw_word_q), .eff_freq_khz_q(eff_freq_khz_q), .input_start_threshold_quarter_v_q(input_start_threshold_quarter_v_q),
  .input_low_fault_mask_q(input_low_fault_mask_q));

// ### test/pmoc_regs_tb.sv
// Self-checking bench for the output configuration command block
`timescale 1ns/1ns
module pmoc_regs_tb;
  import pmoc_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, store_user_all = 1'b0, restore_user_all = 1'b0, conv_en = 1'b0;
  logic analog_supply_uvlo = 1'b0, input_above_start = 1'b0, vout_target_chg = 1'b0, status_clear = 1'b0;
  logic [15:0] vout_target = 16'h2000, rd_data_q, vout_setpoint_q, scale_hw_word_q, rv, w, lfsr_q;
  logic rd_valid_q, output_limit_warning_q, scale_use_programmed_q, input_low_fault_mask_q;
  logic [10:0] eff_freq_khz_q;
  logic [5:0] input_start_threshold_quarter_v_q;
  logic [1:0] div_factor_q;
  pmoc_cmd_t cmd;
  pmoc_status_t status_q;
  int miscompares = 0, checks_done = 0, cycles = 0, k;
  localparam logic [10:0] EDGE [11] = '{11'h0FA, 11'h12C, 11'h15E, 11'h19A, 11'h1F4, 11'h258, 11'h2BC, 11'h334,
    11'h3E8, 11'h4B0, 11'h578};
  localparam logic [10:0] BAND [12] = '{11'h0E1, 11'h113, 11'h145, 11'h177, 11'h1C2, 11'h226, 11'h28A, 11'h2EE,
    11'h384, 11'h44C, 11'h514, 11'h5DC};
  localparam logic [10:0] CORN [4] = '{11'h0FA, 11'h12C, 11'h670, 11'h0F9};
  localparam logic [10:0] SCM [8] = '{11'h00A, 11'h010, 11'h011, 11'h020, 11'h032, 11'h040, 11'h064, 11'h080};
  localparam logic [15:0] VW [4] = '{16'hF029, 16'hF80B, 16'hE82B, 16'hF03F};
  localparam logic [5:0] VQ [4] = '{6'h29, 6'h16, 6'h15, 6'h3F};

  always #4 mclk = ~mclk;

  pmoc_regs #(.NVM_FLOOR(16'h0200), .LIMIT_LO(16'h0100), .LIMIT_HI(16'hF000)) uut (.mclk(mclk), .sys_rst(sys_rst),
    .cmd(cmd), .store_user_all(store_user_all), .restore_user_all(restore_user_all), .conv_en(conv_en),
    .analog_supply_uvlo(analog_supply_uvlo), .input_above_start(input_above_start), .vout_target(vout_target),
    .vout_target_chg(vout_target_chg), .status_clear(status_clear), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .status_q(status_q), .output_limit_warning_q(output_limit_warning_q), .vout_setpoint_q(vout_setpoint_q),
    .div_factor_q(div_factor_q), .scale_use_programmed_q(scale_use_programmed_q),
    .scale_hw_word_q(scale_hw_word_q), .eff_freq_khz_q(eff_freq_khz_q), .input_start_threshold_quarter_v_q(input_start_threshold_quarter_v_q),
    .input_low_fault_mask_q(input_low_fault_mask_q));
  pmoc_host host (.mclk(mclk), .cmd(cmd), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

  function automatic logic [15:0] freq_band(input int f);
    freq_band = {5'h00, BAND[11]};
    for (int i = 10; i >= 0; i--) if (f < EDGE[i]) freq_band = {5'h00, BAND[i]};
  endfunction : freq_band
  function automatic logic [1:0] div_of(input logic [10:0] m);
    div_of = (m <= 11'h010) ? 2'h0 : (m <= 11'h020) ? 2'h1 : (m <= 11'h040) ? 2'h2 : 2'h3;
  endfunction : div_of
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
  endtask : pulse
  task automatic rd_chk(input string name, input logic [7:0] code, input logic [15:0] exp);
    host.rd_word(code, rv);
    check(name, rv, exp);
  endtask : rd_chk

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      stop_test();
    end
  end

  initial
  begin
    lfsr_q = 16'h0036;
    cyc(16);
    sys_rst = 1'b0;
    cyc(2);
    rd_chk("scale_rst", 8'h29, {5'h19, 11'h040});
    rd_chk("floor_rst", 8'h2B, 16'h0200);
    rd_chk("freq_rst", 8'h33, {5'h00, 11'h226});
    rd_chk("vin_rst", 8'h35, {5'h1E, 11'h014});
    rd_chk("unmapped", 8'h34, 16'h0000);
    check("vin_code_rst", {10'h000, input_start_threshold_quarter_v_q}, 16'h0014);
    // Upper bands used here: single phase with an external rail assumed
    for (int i = 0; i < 20; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      k = (i < 4) ? int'(CORN[i]) : 1 + int'(lfsr_q) % 1649;
      if (k > 1023) k = k & ~1;
      w = (k > 1023) ? {5'h01, 11'(k / 2)} : {5'h00, 11'(k)};
      host.wr_word(8'h33, w);
      cyc(2);
      check("eff_freq", {5'h00, eff_freq_khz_q}, freq_band(k));
      rd_chk("freq_rb", 8'h33, w);
    end
    conv_en = 1'b1;
    host.wr_word(8'h33, 16'h012C);
    host.wr_word(8'h29, {5'h19, 11'h020});
    cyc(3);
    check("freq_held", {5'h00, eff_freq_khz_q}, freq_band(k));
    rd_chk("freq_held_rb", 8'h33, 16'h012C);
    check("scale_held", scale_hw_word_q, {5'h19, 11'h040});
    rd_chk("scale_held_rb", 8'h29, {5'h19, 11'h020});
    pulse(store_user_all);
    pulse(restore_user_all);
    cyc(3);
    check("freq_restored", {5'h00, eff_freq_khz_q}, 16'h0145);
    check("scale_restored", scale_hw_word_q, {5'h19, 11'h020});
    host.wr_word(8'h33, 16'h01F4);
    analog_supply_uvlo = 1'b1;
    cyc(4);
    analog_supply_uvlo = 1'b0;
    cyc(8);
    check("freq_uvlo", {5'h00, eff_freq_khz_q}, 16'h0226);
    conv_en = 1'b0;
    foreach (SCM[i])
    begin
      host.wr_word(8'h29, {5'h19, SCM[i]});
      cyc(3);
      check("div", {14'h0000, div_factor_q}, {14'h0000, div_of(SCM[i])});
      check("use_prog", {15'h0000, scale_use_programmed_q},
        {15'h0000, !(SCM[i] inside {11'h010, 11'h020, 11'h040, 11'h080})});
      check("scale_hw", scale_hw_word_q, {5'h19, SCM[i]});
      rd_chk("scale_rb", 8'h29, {5'h19, SCM[i]});
    end
    pulse(status_clear);
    host.wr_word(8'h29, {5'h19, 11'h081});
    cyc(2);
    check("scale_bad", {11'h000, status_q}, 16'h0003);
    rd_chk("scale_kept", 8'h29, {5'h19, 11'h080});
    pulse(status_clear);
    conv_en = 1'b1;
    host.wr_word(8'h2B, 16'hF001);
    cyc(2);
    check("floor_bad", {11'h000, status_q}, 16'h0003);
    rd_chk("floor_kept", 8'h2B, 16'h0200);
    pulse(status_clear);
    host.wr_word(8'h2B, 16'h1000);
    vout_target = 16'h0800;
    pulse(vout_target_chg);
    check("warn", {15'h0000, output_limit_warning_q}, 16'h0001);
    check("setpoint", vout_setpoint_q, 16'h1000);
    check("status", {11'h000, status_q}, 16'h001D);
    pulse(status_clear);
    vout_target = 16'h2000;
    pulse(vout_target_chg);
    check("no_warn", {11'h000, status_q}, 16'h0000);
    host.wr_word(8'h2B, 16'h3000);
    check("floor_warn", {15'h0000, output_limit_warning_q}, 16'h0001);
    cyc(1);
    check("floor_set", vout_setpoint_q, 16'h3000);
    conv_en = 1'b0;
    pulse(status_clear);
    pulse(vout_target_chg);
    check("off_no_warn", {11'h000, status_q}, 16'h0000);
    conv_en = 1'b1;
    foreach (VW[i])
    begin
      host.wr_word(8'h35, VW[i]);
      cyc(2);
      check("vin_code", {10'h000, input_start_threshold_quarter_v_q}, {10'h000, VQ[i]});
      rd_chk("vin_rb", 8'h35, VW[i]);
    end
    check("mask_set", {15'h0000, input_low_fault_mask_q}, 16'h0001);
    input_above_start = 1'b1;
    cyc(5);
    input_above_start = 1'b0;
    conv_en = 1'b0;
    pulse(store_user_all);
    pulse(restore_user_all);
    cyc(3);
    check("mask_kept", {15'h0000, input_low_fault_mask_q}, 16'h0000);
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    cyc(2);
    check("mask_rearm", {15'h0000, input_low_fault_mask_q}, 16'h0001);
    stop_test();
  end
endmodule : pmoc_regs_tb
